// file: core/cms_defines.vh
`ifndef CMS_DEFINES_VH
`define CMS_DEFINES_VH
// operating mode codes reported to the host
`define CMS_MODE_BUCK 2'h0
`define CMS_MODE_BOOST 2'h1
`define CMS_MODE_BB 2'h2
`define CMS_MODE_OTG 2'h3
// debounce times in ms, clock in kHz
`define CMS_DEB_LONG_MS 32'h0000_0514
`define CMS_DEB_SHORT_MS 32'h0000_0096
`define CMS_CLK_KHZ 32'h0000_c350
// config sample settle time in us, clock in MHz (40 us at 50 MHz)
`define CMS_CFG_SETTLE_US 32'h0000_0028
`define CMS_CLK_MHZ 32'h0000_0032
// config code cell field: codes at or above this value are single cell
`define CMS_CFG_ONE_CELL_MIN 4'ha
`define CMS_CFG_RESET 4'h0
`endif

// file: core/cms_debounce_timer.v
`include "cms_defines.vh"
// ----------------------------------------
// adapter debounce timer
// ----------------------------------------
module cms_debounce_timer #(
  parameter CNT_W = 27,
  parameter [CNT_W-1:0] LONG_CYC = 27'd65000000,
  parameter [CNT_W-1:0] SHORT_CYC = 27'd7500000
) (
  input wire i_core_clk, // device clock
  input wire i_reset_n, // async reset, low
  input wire i_run, // count while high, restart when low
  input wire i_use_long, // pick long interval
  output reg o_done // interval elapsed, level
);
  reg [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] limit = i_use_long ? LONG_CYC : SHORT_CYC;

  // count restarts whenever adapter presence drops
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= {CNT_W{1'b0}};
      o_done <= 1'b0;
    end else if (!i_run) begin
      cnt_q <= {CNT_W{1'b0}};
      o_done <= 1'b0;
    end else if (cnt_q >= limit - 1'b1) begin
      o_done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// file: core/cms_bridge_driver.v
`include "cms_defines.vh"
// ----------------------------------------
// four-fet bridge role per mode
// ----------------------------------------
module cms_bridge_driver (
  input wire [1:0] i_mode, // active mode
  input wire i_switch_en, // converter running
  input wire i_pwm, // modulator pulse
  input wire i_diode_emulation_mode, // de mode on
  input wire i_zero_cross, // phase node reached zero
  output reg o_in_hi, // input high fet
  output reg o_in_lo, // input low fet
  output reg o_out_lo, // output low fet
  output reg o_out_hi // output high fet
);
  // sync fet is cut at zero crossing in de mode to stop reverse current
  wire sync_ok = !(i_diode_emulation_mode && i_zero_cross);

  always @* begin
    o_in_hi = 1'b0;
    o_in_lo = 1'b0;
    o_out_lo = 1'b0;
    o_out_hi = 1'b0;
    if (i_switch_en) begin
      case (i_mode)
        `CMS_MODE_BUCK: begin
          o_in_hi = i_pwm;
          o_in_lo = !i_pwm && sync_ok;
          o_out_hi = 1'b1;
        end
        `CMS_MODE_BOOST: begin
          o_in_hi = 1'b1;
          o_out_lo = i_pwm;
          o_out_hi = !i_pwm && sync_ok;
        end
        `CMS_MODE_BB: begin
          o_in_hi = i_pwm;
          o_out_lo = i_pwm;
          o_in_lo = !i_pwm && sync_ok;
          o_out_hi = !i_pwm;
        end
        default: begin
          o_in_hi = 1'b1;
          o_out_hi = i_pwm;
          o_out_lo = !i_pwm && sync_ok;
        end
      endcase
    end
  end
endmodule

// file: core/cms_charger_mode_sequencer.v
// Operation
// - buck: input pair switches, out-high on
// - boost: output pair switches, in-high on
// - buck-boost: diagonal pairs switch together
// - otg: output pair switches, out-high controls
// - rising above 94% moves boost to buck-boost
// - above 120% forces buck
// - falling below 106% moves buck to buck-boost
// - below 80% moves buck-boost to boost
// - otg needs command, pin, battery above 5.8V
// - no otg for single cell
// - otg adapter switch from host bit
// - turbo turns battery switch on
// - idle until bias above 2.7V
// - debounce 1.3s or 150ms by select bit
// - first attach after reset uses 150ms
// - short check blocks adapter switch
// - adapter ok needs bias, sense, switch on
// - non-otg switching only after adapter ok
// - adapter ok driven low without adapter
// - sample config resistor before adapter switch
// - battery-only low power, exit on monitor
// - de cuts sync gate at zero crossing (out-high in boost, low gate otherwise)
// - report mode as two-bit code
// - battery-only config read after monitor enable
`include "cms_defines.vh"
module cms_charger_mode_sequencer #(
  parameter CNT_W = 27,
  parameter [CNT_W-1:0] DEB_LONG_CYC = 27'd65000000,
  parameter [CNT_W-1:0] DEB_SHORT_CYC = 27'd7500000
) (
  input wire i_core_clk, // device clock
  input wire i_reset_n, // async reset, low
  input wire i_bias_above_2v7, // bias supply logic ok
  input wire i_bias_above_3v8, // bias supply high enough
  input wire i_adapter_above_3v2, // adapter present
  input wire i_adp_above_94, // adapter > 94% sys
  input wire i_adp_above_120, // adapter > 120% sys
  input wire i_adp_below_106, // adapter < 106% sys
  input wire i_adp_below_80, // adapter < 80% sys
  input wire i_input_current_sense_pos_above_2v, // short check
  input wire i_adapter_sense_in_above_0v8, // adapter sense ok
  input wire i_adapter_switch_full_on, // switch fully enhanced
  input wire i_battery_above_5v8, // battery flag
  input wire i_otg_cmd, // host otg enable
  input wire i_reverse_mode_enable_pin, // external otg pin
  input wire i_otg_adapter_switch_bit, // host gate bit in otg
  input wire i_turbo_event, // turbo request
  input wire i_debounce_long_sel, // 1 selects long debounce
  input wire i_system_power_monitor_en, // host monitor enable
  input wire [3:0] i_config_resistor_code, // decoded resistor code
  input wire i_diode_emulation_mode, // de mode
  input wire i_zero_cross, // phase zero crossing
  input wire i_pwm, // modulator pulse
  output reg o_adapter_switch_gate, // adapter switch on
  output reg o_adapter_ok_out, // open-drain output enable, low drives
  output reg o_config_resistor_source, // 10 uA source on
  output reg [3:0] o_config_code, // latched configuration
  output reg o_battery_switch_gate, // battery switch on
  output reg o_low_power, // low power mode
  output reg o_host_ready, // register interface live
  output reg o_switching, // converter running
  output reg [1:0] o_mode, // active mode code
  output reg o_input_high_fet, // fet gate
  output reg o_input_low_fet, // fet gate
  output reg o_output_low_fet, // fet gate
  output reg o_output_high_fet // fet gate
);
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  localparam [5:0] S_OFF = 6'h01;
  localparam [5:0] S_BATT = 6'h02;
  localparam [5:0] S_DEB = 6'h04;
  localparam [5:0] S_CFG = 6'h08;
  localparam [5:0] S_GATE = 6'h10;
  localparam [5:0] S_RUN = 6'h20;
  localparam [31:0] SETTLE_FULL = `CMS_CFG_SETTLE_US * `CMS_CLK_MHZ;
  // settle counter is one byte wide, so only the low byte of the count is kept
  localparam [7:0] SETTLE_CYC = SETTLE_FULL[7:0];

  reg [5:0] state_q;
  reg [5:0] state_d;
  reg first_attach_q;
  reg cfg_valid_q;
  reg [7:0] settle_q;
  reg [1:0] conv_mode_q;
  reg [1:0] conv_mode_d;
  reg short_seen_q;
  reg mon_q; // monitor enable one cycle late, for its rising edge
  wire deb_done;
  wire gate_in_hi;
  wire gate_in_lo;
  wire gate_out_lo;
  wire gate_out_hi;

  function is_one_cell;
    input [3:0] code;
    begin
      is_one_cell = (code >= `CMS_CFG_ONE_CELL_MIN);
    end
  endfunction

  wire adapter_ok = i_bias_above_3v8 && i_adapter_sense_in_above_0v8 &&
    i_adapter_switch_full_on;
  // release and switching share one term so they drop in the same cycle
  wire adapter_ok_out_cond = adapter_ok && i_adapter_above_3v2;
  wire otg_req = i_otg_cmd && i_reverse_mode_enable_pin && i_battery_above_5v8 &&
    cfg_valid_q && !is_one_cell(o_config_code);
  wire in_deb = (state_q == S_DEB);

  // ----------------------------------------
  // debounce timing
  // ----------------------------------------
  // first attach after reset always uses the short interval
  cms_debounce_timer #(
    .CNT_W(CNT_W),
    .LONG_CYC(DEB_LONG_CYC),
    .SHORT_CYC(DEB_SHORT_CYC)
  ) u_deb (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_run(in_deb && i_adapter_above_3v2),
    .i_use_long(i_debounce_long_sel && !first_attach_q),
    .o_done(deb_done)
  );

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      S_OFF: begin
        if (i_bias_above_2v7) begin
          state_d = S_BATT;
        end
      end
      S_BATT: begin
        if (i_adapter_above_3v2 && !otg_req) begin
          state_d = S_DEB;
        end
      end
      S_DEB: begin
        if (!i_adapter_above_3v2) begin
          state_d = S_BATT;
        end else if (deb_done && !short_seen_q) begin
          state_d = S_CFG;
        end
      end
      S_CFG: begin
        if (!i_adapter_above_3v2) begin
          state_d = S_BATT;
        end else if (settle_q == 8'h00) begin
          state_d = S_GATE;
        end
      end
      S_GATE: begin
        if (!i_adapter_above_3v2) begin
          state_d = S_BATT;
        end else if (adapter_ok) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (!i_adapter_above_3v2 || !adapter_ok) begin
          state_d = S_BATT;
        end
      end
      default: state_d = S_OFF;
    endcase
    if (!i_bias_above_2v7) begin
      state_d = S_OFF;
    end
  end

  // ----------------------------------------
  // converter mode with hysteresis
  // ----------------------------------------
  // only the crossing flags and the otg request move the mode; between them it holds
  always @* begin
    conv_mode_d = conv_mode_q;
    if (conv_mode_q == `CMS_MODE_OTG) begin
      conv_mode_d = `CMS_MODE_BB;
    end else if (i_adp_above_120) begin
      conv_mode_d = `CMS_MODE_BUCK;
    end else if (conv_mode_q == `CMS_MODE_BOOST && i_adp_above_94) begin
      conv_mode_d = `CMS_MODE_BB;
    end else if (conv_mode_q == `CMS_MODE_BUCK && i_adp_below_106) begin
      conv_mode_d = `CMS_MODE_BB;
    end else if (conv_mode_q == `CMS_MODE_BB && i_adp_below_80) begin
      conv_mode_d = `CMS_MODE_BOOST;
    end
    if (state_q == S_BATT && otg_req) begin
      conv_mode_d = `CMS_MODE_OTG;
    end
  end

  cms_bridge_driver u_bridge (
    .i_mode(conv_mode_q),
    .i_switch_en(o_switching),
    .i_pwm(i_pwm),
    .i_diode_emulation_mode(i_diode_emulation_mode),
    .i_zero_cross(i_zero_cross),
    .o_in_hi(gate_in_hi),
    .o_in_lo(gate_in_lo),
    .o_out_lo(gate_out_lo),
    .o_out_hi(gate_out_hi)
  );

  // ----------------------------------------
  // state and bookkeeping registers
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= S_OFF;
      first_attach_q <= 1'b1;
      cfg_valid_q <= 1'b0;
      settle_q <= 8'h00;
      conv_mode_q <= `CMS_MODE_BB;
      short_seen_q <= 1'b0;
      mon_q <= 1'b0;
      o_config_code <= `CMS_CFG_RESET;
    end else begin
      state_q <= state_d;
      conv_mode_q <= conv_mode_d;
      // host may re-enable the monitor to ask for a fresh config read
      mon_q <= i_system_power_monitor_en;
      // short check during debounce; sticky until adapter leaves
      if (state_q != S_DEB) begin
        short_seen_q <= 1'b0;
      end else if (!i_input_current_sense_pos_above_2v ||
                   !i_adapter_sense_in_above_0v8) begin
        short_seen_q <= 1'b1;
      end
      if (state_q == S_GATE) begin
        first_attach_q <= 1'b0;
      end
      // config read: adapter path, or battery-only on each monitor enable
      if (state_d == S_CFG && state_q != S_CFG) begin
        settle_q <= SETTLE_CYC;
      end else if (state_q == S_CFG && state_d != S_CFG) begin
        // adapter left mid-read: drop the sample rather than latch it late
        settle_q <= 8'h00;
      end else if (state_q == S_BATT && i_system_power_monitor_en &&
                   !mon_q && settle_q == 8'h00) begin
        settle_q <= SETTLE_CYC;
      end else if (settle_q != 8'h00) begin
        settle_q <= settle_q - 8'h01;
        if (settle_q == 8'h01) begin
          o_config_code <= i_config_resistor_code;
          cfg_valid_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_adapter_switch_gate <= 1'b0;
      o_adapter_ok_out <= 1'b0;
      o_config_resistor_source <= 1'b0;
      o_battery_switch_gate <= 1'b0;
      o_low_power <= 1'b0;
      o_host_ready <= 1'b0;
      o_switching <= 1'b0;
      o_mode <= `CMS_MODE_BB;
      o_input_high_fet <= 1'b0;
      o_input_low_fet <= 1'b0;
      o_output_low_fet <= 1'b0;
      o_output_high_fet <= 1'b0;
    end else begin
      o_host_ready <= (state_q != S_OFF);
      if (conv_mode_q == `CMS_MODE_OTG) begin
        o_adapter_switch_gate <= i_otg_adapter_switch_bit;
      end else begin
        o_adapter_switch_gate <= (state_q == S_GATE) || (state_q == S_RUN);
      end
      // enable low drives the line low; released only while the adapter is good
      o_adapter_ok_out <= adapter_ok_out_cond;
      o_config_resistor_source <= (settle_q != 8'h00);
      o_battery_switch_gate <= (state_q == S_BATT && conv_mode_q != `CMS_MODE_OTG) ||
        (state_q == S_RUN && i_turbo_event);
      o_low_power <= (state_q == S_BATT) && !i_system_power_monitor_en &&
        (conv_mode_q != `CMS_MODE_OTG);
      // outside otg, one cycle behind the release, never ahead of it
      o_switching <= (state_q == S_RUN && adapter_ok_out_cond) ||
        (conv_mode_q == `CMS_MODE_OTG && state_q == S_BATT);
      o_mode <= conv_mode_q;
      o_input_high_fet <= gate_in_hi;
      o_input_low_fet <= gate_in_lo;
      o_output_low_fet <= gate_out_lo;
      o_output_high_fet <= gate_out_hi;
    end
  end
endmodule

// file: sim/cms_charger_mode_sequencer_monitor.sv
module cms_charger_mode_sequencer_monitor (
  input wire logic i_core_clk, // clock
  input wire logic i_reset_n, // async reset, low
  input wire logic i_bias_above_2v7, // bias logic ok
  input wire logic i_bias_above_3v8, // bias high
  input wire logic i_adapter_above_3v2, // adapter present
  input wire logic i_adp_above_120, // ratio flag
  input wire logic i_adapter_sense_in_above_0v8, // sense ok
  input wire logic i_adapter_switch_full_on, // switch on
  input wire logic i_battery_above_5v8, // battery flag
  input wire logic i_otg_cmd, // host otg
  input wire logic i_reverse_mode_enable_pin, // otg pin
  input wire logic i_otg_adapter_switch_bit, // otg gate bit
  input wire logic i_turbo_event, // turbo
  input wire logic i_diode_emulation_mode, // de mode
  input wire logic i_zero_cross, // zero crossing
  input wire logic o_adapter_switch_gate, // adapter switch
  input wire logic o_adapter_ok_out, // open-drain enable
  input wire logic o_config_resistor_source, // 10 uA source
  input wire logic [3:0] o_config_code, // latched config
  input wire logic o_battery_switch_gate, // battery switch
  input wire logic o_host_ready, // host live
  input wire logic o_switching, // converter running
  input wire logic [1:0] o_mode, // mode code
  input wire logic o_input_low_fet, // fet
  input wire logic o_output_low_fet, // fet
  input wire logic o_output_high_fet // fet
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // port relations, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // config sampling must finish right before the switch closes
  sequence s_cfg_end;
    $fell(o_config_resistor_source) && i_adapter_above_3v2;
  endsequence
  sequence s_buck_run;
    (o_switching && o_mode == 2'h0) [*2];
  endsequence
  a_buck_out_roles: assert property (s_buck_run ##1 (o_switching && o_mode == 2'h0)
    |-> o_output_high_fet && !o_output_low_fet) else $error("buck output pair roles wrong");
  a_force_buck: assert property ((o_switching && i_adp_above_120) [*3] |=> o_mode == 2'h0)
    else $error("high ratio did not force buck");
  a_otg_guard: assert property ($rose(o_mode == 2'h3) |-> o_config_code < 4'ha &&
    $past(i_otg_cmd && i_reverse_mode_enable_pin && i_battery_above_5v8, 2))
    else $error("reverse mode entered without its conditions");
  a_otg_gate_bit: assert property ((o_mode == 2'h3 && $stable(i_otg_adapter_switch_bit)) [*3]
    |-> o_adapter_switch_gate == i_otg_adapter_switch_bit) else $error("otg gate not from bit");
  a_turbo_battery: assert property ((o_switching && i_turbo_event) [*3] |=> o_battery_switch_gate)
    else $error("turbo left battery switch off");
  a_host_wait: assert property ($rose(o_host_ready) |-> $past(i_bias_above_2v7, 2))
    else $error("host ready without bias");
  a_adapter_ok_out_release: assert property ($rose(o_adapter_ok_out) |->
    $past(i_bias_above_3v8 && i_adapter_sense_in_above_0v8 && i_adapter_switch_full_on &&
    i_adapter_above_3v2))
    else $error("adapter ok released early");
  a_switch_after_ok: assert property ((o_switching && o_mode != 2'h3) |-> o_adapter_ok_out)
    else $error("switching without adapter ok");
  a_adapter_ok_out_low_idle: assert property (!i_adapter_above_3v2 [*2] |=> !o_adapter_ok_out)
    else $error("adapter ok released without adapter");
  a_cfg_before_gate: assert property (s_cfg_end |-> ##[0:3] o_adapter_switch_gate)
    else $error("switch not closed after config read");
  a_de_cut: assert property ((i_diode_emulation_mode && i_zero_cross && o_mode == 2'h0) [*2]
    |=> !o_input_low_fet) else $error("low gate kept on at zero crossing");
endmodule

// file: sim/cms_fet_bridge_model.sv
module cms_fet_bridge_model #(
  parameter int ON_DLY = 5
) (
  input wire logic i_core_clk, // clock
  input wire logic i_gate, // adapter switch gate command
  output logic o_full_on = 1'b0 // switch fully enhanced
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // gate charge takes a few cycles; release drops enhancement at once
  always @(negedge i_core_clk) begin
    cnt <= i_gate ? cnt + 1 : 0;
    o_full_on <= i_gate && cnt >= ON_DLY;
  end
endmodule

// file: sim/cms_charger_mode_sequencer_tb.sv
module cms_charger_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, adp = 1'b0, csp = 1'b1, pwm = 1'b0, de = 1'b0, zc = 1'b0;
  logic a94 = 1'b0, a120 = 1'b0, b106 = 1'b0, b80 = 1'b0, otg = 1'b0, pin = 1'b0, abit = 1'b0;
  logic turbo = 1'b0, sel = 1'b0, mon = 1'b0, hi = 1'b1;
  logic [3:0] cfg = 4'h5;
  wire gate, ok, src, battery_switch_gate, lowp, hrdy, sw, ih, il, ol, oh, full_on;
  wire [3:0] code;
  wire [1:0] mode;
  int miscompares = 0, checked = 0;
  // ----------------------------------------
  // design, far side, clock
  // ----------------------------------------
  cms_charger_mode_sequencer #(.DEB_LONG_CYC(27'd40), .DEB_SHORT_CYC(27'd20))
    u_cms_charger_mode_sequencer (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_bias_above_2v7(hi), .i_bias_above_3v8(hi), .i_adapter_above_3v2(adp),
    .i_adp_above_94(a94), .i_adp_above_120(a120), .i_adp_below_106(b106), .i_adp_below_80(b80),
    .i_input_current_sense_pos_above_2v(csp), .i_adapter_sense_in_above_0v8(hi),
    .i_adapter_switch_full_on(full_on), .i_battery_above_5v8(hi), .i_otg_cmd(otg),
    .i_reverse_mode_enable_pin(pin), .i_otg_adapter_switch_bit(abit), .i_turbo_event(turbo),
    .i_debounce_long_sel(sel), .i_system_power_monitor_en(mon), .i_config_resistor_code(cfg),
    .i_diode_emulation_mode(de), .i_zero_cross(zc), .i_pwm(pwm), .o_adapter_switch_gate(gate),
    .o_adapter_ok_out(ok), .o_config_resistor_source(src), .o_config_code(code),
    .o_battery_switch_gate(battery_switch_gate), .o_low_power(lowp), .o_host_ready(hrdy), .o_switching(sw),
    .o_mode(mode), .o_input_high_fet(ih), .o_input_low_fet(il), .o_output_low_fet(ol),
    .o_output_high_fet(oh));
  cms_fet_bridge_model u_cms_fet_bridge_model (.i_core_clk(clk), .i_gate(gate), .o_full_on(full_on));
  initial begin
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // fet roles sampled once the registered gates settle
  task automatic chk_fets(input logic [3:0] on, input logic [3:0] off);
    pwm = 1'b1;
    cyc(3);
    chk("fets_pwm_on", on, {ih, il, ol, oh});
    pwm = 1'b0;
    cyc(3);
    chk("fets_pwm_off", off, {ih, il, ol, oh});
  endtask
  task automatic ratio(input logic [3:0] f, input logic [1:0] m);
    {a94, a120, b106, b80} = f;
    cyc(4);
    chk("mode", {2'h0, m}, {2'h0, mode});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_attach;
    sel = 1'b1;
    adp = 1'b1;
    cyc(30);
    chk("cfg_source_first", 4'h1, {3'h0, src});
    chk("gate_before_cfg", 4'h0, {3'h0, gate});
    for (int i = 0; i < 400 && sw !== 1'b1; i++) cyc(1);
    chk("cfg_code", 4'h5, code);
    chk("adapter_ok_out_run", 4'h1, {3'h0, ok});
    chk("switching", 4'h1, {3'h0, sw});
    turbo = 1'b1;
    cyc(4);
    chk("turbo_battery_switch_gate", 4'h1, {3'h0, battery_switch_gate});
    turbo = 1'b0;
  endtask
  task automatic t_modes;
    ratio(4'b1100, 2'h0);
    chk_fets(4'b1001, 4'b0101);
    de = 1'b1;
    zc = 1'b1;
    cyc(3);
    chk("de_low_gate", 4'h0, {3'h0, il});
    de = 1'b0;
    zc = 1'b0;
    ratio(4'b1000, 2'h0);
    ratio(4'b1010, 2'h2);
    chk_fets(4'b1010, 4'b0101);
    ratio(4'b0011, 2'h1);
    chk_fets(4'b1010, 4'b1001);
    ratio(4'b0010, 2'h1);
    ratio(4'b1010, 2'h2);
  endtask
  task automatic t_short;
    adp = 1'b0;
    cyc(4);
    chk("adapter_ok_out_removed", 4'h0, {3'h0, ok});
    csp = 1'b0;
    adp = 1'b1;
    cyc(300);
    chk("gate_short", 4'h0, {3'h0, gate});
    adp = 1'b0;
    csp = 1'b1;
    cyc(3);
    adp = 1'b1;
    cyc(30);
    chk("deb_long", 4'h0, {3'h0, src});
    adp = 1'b0;
    cyc(2);
    adp = 1'b1;
    cyc(30);
    chk("deb_restart", 4'h0, {3'h0, src});
    cyc(20);
    chk("deb_long_done", 4'h1, {3'h0, src});
  endtask
  task automatic t_otg;
    adp = 1'b0;
    cyc(8);
    chk("low_power", 4'h1, {3'h0, lowp});
    cfg = 4'hb;
    mon = 1'b1;
    cyc(300);
    chk("low_power_exit", 4'h0, {3'h0, lowp});
    chk("cfg_batt", 4'hb, code);
    otg = 1'b1;
    pin = 1'b1;
    cyc(6);
    chk("otg_one_cell", 4'h0, {3'h0, mode == 2'h3});
    cfg = 4'h5;
    mon = 1'b0;
    cyc(2);
    mon = 1'b1;
    cyc(300);
    chk("otg_mode", 4'h3, {2'h0, mode});
    chk_fets(4'b1001, 4'b1010);
    abit = 1'b1;
    cyc(4);
    chk("otg_gate_on", 4'h1, {3'h0, gate});
    abit = 1'b0;
    cyc(4);
    chk("otg_gate_off", 4'h0, {3'h0, gate});
    pin = 1'b0;
    cyc(4);
    chk("otg_pin_off", 4'h2, {2'h0, mode});
  endtask
  // main sequence; reset outputs looked at before release
  initial begin
    cyc(15);
    chk("mode_reset", 4'h2, {2'h0, mode});
    chk("adapter_ok_out_reset", 4'h0, {3'h0, ok});
    cyc(1);
    rst_n = 1'b1;
    cyc(3);
    chk("host_ready", 4'h1, {3'h0, hrdy});
    t_attach;
    t_modes;
    t_short;
    t_otg;
    final_report;
  end
  // whole run is near 1300 cycles; fifteen times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule
bind cms_charger_mode_sequencer cms_charger_mode_sequencer_monitor u_cms_charger_mode_sequencer_monitor (.*);
